// File: shared/sspc_pkg.sv
package sspc_pkg;

    // ----------------------------------------------------------------
    // Counter constants
    // ----------------------------------------------------------------
    localparam int COUNT_WIDTH = 4;
    localparam int DECADE_MODULUS = 10;
    localparam int BINARY_MODULUS = 16;
    localparam logic [3:0] DECADE_TERMINAL = 4'h9;
    localparam logic [3:0] BINARY_TERMINAL = 4'hf;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam int WRAP_WIDTH = 16;

    // ----------------------------------------------------------------
    // Register port constants
    // ----------------------------------------------------------------
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 32;
    localparam logic [3:0] OFFS_STATUS = 4'h0;
    localparam logic [3:0] OFFS_CONTROL = 4'h4;
    localparam logic [3:0] OFFS_WRAPS = 4'h8;
    localparam logic [3:0] OFFS_CONFIG = 4'hc;
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_TC_BIT = 4;
    localparam int STATUS_MODE_LSB = 8;
    localparam int CONTROL_HOLD_BIT = 0;
    localparam int CONFIG_ASYNC_BIT = 8;
    localparam int CONFIG_MODULUS_LSB = 0;
    localparam logic CONTROL_HOLD_RESET = 1'b0;
    localparam logic [15:0] WRAPS_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_CLEAR = 4'b0001,
        MODE_LOAD = 4'b0010,
        MODE_COUNT = 4'b0100,
        MODE_HOLD = 4'b1000
    } sspc_mode_t;

    typedef struct packed {
        logic parallelCountEnable;
        logic trickleCountEnable;
        logic loadEnableN;
    } sspc_ctrl_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sspc_bus_req_t;

    typedef struct packed {
        logic [3:0] count;
        logic tc;
        sspc_mode_t mode;
        logic softHold;
        logic [15:0] wraps;
        logic [31:0] rdata;
    } sspc_state_t;

    localparam sspc_state_t STATE_RESET = '{
        count: COUNT_RESET,
        tc: 1'b0,
        mode: MODE_CLEAR,
        softHold: CONTROL_HOLD_RESET,
        wraps: WRAPS_RESET,
        rdata: RDATA_RESET
    };

endpackage

// File: hw/sspc_lookahead.sv
`timescale 1ns/1ps
module sspc_lookahead
    import sspc_pkg::*;
#(
    parameter int MODULUS = BINARY_MODULUS
)
(
    // Present count and step request
    input logic [3:0] count,
    input logic advance,
    // Stepped count and terminal detection
    output logic [3:0] nextCount,
    output logic atTerminal
);

    // ----------------------------------------------------------------
    // Terminal detection
    // ----------------------------------------------------------------
    localparam logic [3:0] TERMINAL = (MODULUS == DECADE_MODULUS) ?
        DECADE_TERMINAL : BINARY_TERMINAL;

    assign atTerminal = (count == TERMINAL);

    // ----------------------------------------------------------------
    // Look-ahead carries
    // ----------------------------------------------------------------
    // Every carry is one wide AND of the lower bits, so no carry waits on
    // the one below it; stage delay stays flat as the width grows.
    logic [3:0] carry;

    genvar i;
    generate
        for (i = 0; i < COUNT_WIDTH; i++)
        begin : gCarry
            if (i == 0)
            begin : gFirst
                assign carry[i] = advance;
            end
            else
            begin : gRest
                assign carry[i] = advance & (&count[i-1:0]);
            end
        end
    endgenerate

    always_comb
    begin
        if (advance && atTerminal)
        begin
            nextCount = COUNT_RESET;
        end
        else
        begin
            nextCount = count ^ carry;
        end
    end

endmodule // sspc_lookahead

// File: hw/sspc_counter.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sspc_counter
    import sspc_pkg::*;
#(
    parameter int MODULUS = BINARY_MODULUS,
    parameter bit ASYNC_CLEAR = 1'b1
)
(
    // Clock and system reset
    input logic clock,
    input logic rst_n,

    // Clear pins
    input logic asyncClearN,
    input logic syncClearN,

    // Count control pins
    input sspc_ctrl_t countCtrl,
    input logic [3:0] presetInputs,

    // Count outputs
    output logic [3:0] countOutputs,
    output logic terminalCountFlag,

    // Register port
    input sspc_bus_req_t busReq,
    output logic [31:0] busRdata
);

    // ----------------------------------------------------------------
    // Build-time checks of the variant
    // ----------------------------------------------------------------
    // The variant is frozen at build time; an unsupported modulus would
    // silently give a counter with no documented terminal value.
    localparam bit IS_DECADE = (MODULUS == DECADE_MODULUS);
    localparam logic [7:0] MODULUS_CODE = 8'(MODULUS);

    generate
        if (MODULUS != DECADE_MODULUS && MODULUS != BINARY_MODULUS)
        begin : gBadModulus
            $error("Counter modulus must be ten or sixteen");
        end
        if (COUNT_WIDTH != 4)
        begin : gBadWidth
            $error("Counter must be four bits wide");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic logic regHit(
        input logic [3:0] addr,
        input logic [3:0] offs
    );
        regHit = (addr == offs);
    endfunction

    function automatic sspc_mode_t pickMode(
        input logic clearActive,
        input logic loadActive,
        input logic countActive
    );
        if (clearActive)
        begin
            pickMode = MODE_CLEAR;
        end
        else if (loadActive)
        begin
            pickMode = MODE_LOAD;
        end
        else if (countActive)
        begin
            pickMode = MODE_COUNT;
        end
        else
        begin
            pickMode = MODE_HOLD;
        end
    endfunction

    // One decode of the terminal value serves the flag path; the stepping
    // module keeps its own copy for the wrap.
    function automatic logic [3:0] terminalValue(
        input logic isDecade
    );
        if (isDecade)
        begin
            terminalValue = DECADE_TERMINAL;
        end
        else
        begin
            terminalValue = BINARY_TERMINAL;
        end
    endfunction

    // Read words start from a cleared word so that unused bits read 0.
    function automatic logic [31:0] statusWord(
        input logic [3:0] count,
        input logic tc,
        input sspc_mode_t mode
    );
        logic [31:0] word;
        word = RDATA_RESET;
        word[STATUS_COUNT_LSB +: COUNT_WIDTH] = count;
        word[STATUS_TC_BIT] = tc;
        word[STATUS_MODE_LSB +: 4] = mode;
        statusWord = word;
    endfunction

    function automatic logic [31:0] controlWord(
        input logic softHold
    );
        logic [31:0] word;
        word = RDATA_RESET;
        word[CONTROL_HOLD_BIT] = softHold;
        controlWord = word;
    endfunction

    function automatic logic [31:0] wrapsWord(
        input logic [15:0] wraps
    );
        logic [31:0] word;
        word = RDATA_RESET;
        word[WRAP_WIDTH-1:0] = wraps;
        wrapsWord = word;
    endfunction

    // The variant is fixed at build time, so this word is a constant.
    function automatic logic [31:0] configWord();
        logic [31:0] word;
        word = RDATA_RESET;
        word[CONFIG_MODULUS_LSB +: 8] = MODULUS_CODE;
        word[CONFIG_ASYNC_BIT] = ASYNC_CLEAR;
        configWord = word;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sspc_state_t state_reg;
    sspc_state_t state_next;

    logic clearRstN;
    logic syncClearActive;
    logic loadActive;
    logic countActive;
    logic advance;
    logic atTerminal;
    logic [3:0] steppedCount;
    logic nextAtTerminal;
    logic wrapEvent;
    sspc_mode_t modeNext;
    logic writeControl;
    logic writeWraps;
    logic readStatus;
    logic readControl;
    logic readWraps;
    logic readConfig;

    // ----------------------------------------------------------------
    // Clear selection
    // ----------------------------------------------------------------
    // The asynchronous variant folds the clear pin into the flop reset so
    // that clearing needs no clock edge. The pin only gates a constant
    // reset value in; no data path ever reads it. The synchronous variant
    // leaves the reset to rst_n alone and clears through the next state.
    generate
        if (ASYNC_CLEAR)
        begin : gAsyncClear
            assign clearRstN = rst_n & asyncClearN;
            assign syncClearActive = 1'b0;
        end
        else
        begin : gSyncClear
            assign clearRstN = rst_n;
            assign syncClearActive = ~syncClearN;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Operating mode decode
    // ----------------------------------------------------------------
    // Load takes priority over the enables, clear over everything.
    assign loadActive = ~countCtrl.loadEnableN;
    assign countActive = countCtrl.parallelCountEnable
        & countCtrl.trickleCountEnable
        & ~state_reg.softHold;
    assign modeNext = pickMode(syncClearActive, loadActive, countActive);
    assign advance = (modeNext == MODE_COUNT);

    // ----------------------------------------------------------------
    // Register port decode
    // ----------------------------------------------------------------
    // Writes to read-only or unmapped offsets hit nothing here and are
    // dropped; the port never stalls, so every strobe is final.
    assign writeControl = busReq.wr & regHit(busReq.addr, OFFS_CONTROL);
    assign writeWraps = busReq.wr & regHit(busReq.addr, OFFS_WRAPS);
    assign readStatus = busReq.rd & regHit(busReq.addr, OFFS_STATUS);
    assign readControl = busReq.rd & regHit(busReq.addr, OFFS_CONTROL);
    assign readWraps = busReq.rd & regHit(busReq.addr, OFFS_WRAPS);
    assign readConfig = busReq.rd & regHit(busReq.addr, OFFS_CONFIG);

    // ----------------------------------------------------------------
    // Look-ahead stepping
    // ----------------------------------------------------------------
    sspc_lookahead #(
        .MODULUS(MODULUS)
    ) uStep (
        .count(state_reg.count),
        .advance(advance),
        .nextCount(steppedCount),
        .atTerminal(atTerminal)
    );

    assign wrapEvent = advance & atTerminal;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        // The mode only records which branch the edge took, so software
        // can tell a held counter from a loaded one.
        state_next.mode = modeNext;

        case (modeNext)
            MODE_CLEAR:
            begin
                state_next.count = COUNT_RESET;
            end
            MODE_LOAD:
            begin
                state_next.count = presetInputs;
            end
            MODE_COUNT:
            begin
                state_next.count = steppedCount;
            end
            MODE_HOLD:
            begin
                state_next.count = state_reg.count;
            end
            default:
            begin
                state_next.count = COUNT_RESET;
            end
        endcase

        // The flag is formed from the count that will stand after this
        // edge, so it leaves the flop in step with the count outputs.
        nextAtTerminal = (state_next.count == terminalValue(IS_DECADE));
        state_next.tc = nextAtTerminal
            & countCtrl.trickleCountEnable
            & (modeNext != MODE_CLEAR);

        // Software control of the counter.
        if (writeControl)
        begin
            state_next.softHold = busReq.wdata[CONTROL_HOLD_BIT];
        end

        // A wrap in the same cycle as a clearing write still counts.
        if (writeWraps)
        begin
            state_next.wraps = wrapEvent ? 16'h0001 : WRAPS_RESET;
        end
        else if (wrapEvent)
        begin
            state_next.wraps = 16'(state_reg.wraps + 16'h0001);
        end

        // Read data stand for exactly one cycle after the strobe.
        state_next.rdata = RDATA_RESET;
        if (readStatus)
        begin
            state_next.rdata = statusWord(state_reg.count, state_reg.tc, state_reg.mode);
        end
        else if (readControl)
        begin
            state_next.rdata = controlWord(state_reg.softHold);
        end
        else if (readWraps)
        begin
            state_next.rdata = wrapsWord(state_reg.wraps);
        end
        else if (readConfig)
        begin
            state_next.rdata = configWord();
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // All state moves only on the rising edge; the asynchronous clear
    // loads the constant reset image and nothing else.
    always_ff @(posedge clock or negedge clearRstN)
    begin
        if (!clearRstN)
        begin
            state_reg <= STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Every output leaves a flop, so a following stage sees terminal
    // count one edge after this stage's trickle enable changes; a
    // cascade must budget for that edge.
    assign countOutputs = state_reg.count;
    assign terminalCountFlag = state_reg.tc;
    assign busRdata = state_reg.rdata;

endmodule // sspc_counter

// File: test/sspc_counter_checker.sv
`timescale 1ns/1ps
module sspc_counter_checker
    import sspc_pkg::*;
#(
    parameter int MODULUS = BINARY_MODULUS,
    parameter bit ASYNC_CLEAR = 1'b1
)
(
    // Clock, reset and clears
    input logic clock,
    input logic rst_n,
    input logic asyncClearN,
    input logic syncClearN,
    // Counter pins
    input sspc_ctrl_t countCtrl,
    input logic [3:0] presetInputs,
    input logic [3:0] countOutputs,
    input logic terminalCountFlag,
    // Register port
    input sspc_bus_req_t busReq,
    input logic [31:0] busRdata
);
    localparam logic [3:0] TERM = (MODULUS == 10) ? DECADE_TERMINAL : BINARY_TERMINAL;
    logic clrNow;
    logic holdRst_n;
    logic holdReg;
    logic idleNow;
    assign clrNow = ASYNC_CLEAR ? !asyncClearN : !syncClearN;
    assign holdRst_n = rst_n & (asyncClearN | !ASYNC_CLEAR);
    assign idleNow = !countCtrl.parallelCountEnable || !countCtrl.trickleCountEnable || holdReg;

    // Mirror of the software hold bit; counting depends on it but it is not a port.
    always_ff @(posedge clock or negedge holdRst_n)
    begin
        if (!holdRst_n)
        begin
            holdReg <= 1'b0;
        end
        else if (busReq.wr && busReq.addr == OFFS_CONTROL)
        begin
            holdReg <= busReq.wdata[0];
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    // An asynchronous clear aborts every check in flight except AST_ASYNC_CLEAR, as it aborts the counter.
    default disable iff (!holdRst_n);

    AST_ASYNC_CLEAR: assert property (disable iff (!rst_n)
        ASYNC_CLEAR && !asyncClearN |-> countOutputs == 4'h0 && !terminalCountFlag)
        else $error("async clear did not zero the count");
    AST_SYNC_CLEAR: assert property (
        !ASYNC_CLEAR && !syncClearN |=> countOutputs == 4'h0 && !terminalCountFlag)
        else $error("sync clear did not zero the count");
    AST_LOAD: assert property (
        !clrNow && !countCtrl.loadEnableN |=> countOutputs == $past(presetInputs))
        else $error("load did not copy the presets");
    AST_COUNT: assert property (!clrNow && countCtrl.loadEnableN && !idleNow |=>
        countOutputs == (($past(countOutputs) == TERM) ? 4'h0 : $past(countOutputs) + 4'h1))
        else $error("count did not step by one");
    AST_HOLD: assert property (
        !clrNow && countCtrl.loadEnableN && idleNow |=> $stable(countOutputs))
        else $error("count moved while disabled");
    AST_TC: assert property (!clrNow |=>
        terminalCountFlag == (countOutputs == TERM && $past(countCtrl.trickleCountEnable)))
        else $error("terminal count wrong");
    AST_TC_VALUE: assert property (terminalCountFlag |-> countOutputs == TERM)
        else $error("terminal count away from terminal value");
    AST_RDATA_IDLE: assert property (!$past(busReq.rd) |-> busRdata == 32'h0)
        else $error("read data outside its cycle");
    AST_CONFIG: assert property (busReq.rd && busReq.addr == OFFS_CONFIG |=>
        busRdata == {23'h0, ASYNC_CLEAR, 8'(MODULUS)})
        else $error("config read wrong");

    COV_WRAP: cover property (
        !clrNow && countCtrl.loadEnableN && !idleNow && countOutputs == TERM);
    COV_LOAD: cover property (!clrNow && !countCtrl.loadEnableN);
    COV_TC: cover property (terminalCountFlag);
endmodule // sspc_counter_checker

bind sspc_counter sspc_counter_checker #(.MODULUS(MODULUS), .ASYNC_CLEAR(ASYNC_CLEAR))
    u_sspc_counter_checker (
    .clock(clock), .rst_n(rst_n), .asyncClearN(asyncClearN), .syncClearN(syncClearN),
    .countCtrl(countCtrl), .presetInputs(presetInputs), .countOutputs(countOutputs),
    .terminalCountFlag(terminalCountFlag), .busReq(busReq), .busRdata(busRdata));

// File: test/sspc_pin_driver.sv
`timescale 1ns/1ps
module sspc_pin_driver
    import sspc_pkg::*;
(
    // Pins driven into the counter
    output sspc_ctrl_t countCtrl,
    output logic [3:0] presetInputs,
    output logic asyncClearN,
    output logic syncClearN
);
    initial
    begin
        countCtrl = '{1'b0, 1'b0, 1'b1};
        presetInputs = 4'h0;
        asyncClearN = 1'b1;
        syncClearN = 1'b1;
    end

    // Called at a rising edge; values then stand for a whole cycle before the next edge.
    task automatic drive(input logic loadN, input logic pce, input logic tce, input logic [3:0] p);
        countCtrl <= '{pce, tce, loadN};
        presetInputs <= p;
    endtask

    task automatic clears(input logic a, input logic s);
        asyncClearN <= a;
        syncClearN <= s;
    endtask
endmodule // sspc_pin_driver

// File: test/sspc_counter_bench.sv
`timescale 1ns/1ps
module sspc_counter_bench
    import sspc_pkg::*;
;
    typedef struct packed {
        logic [2:0] ctl;
        logic [3:0] pre;
        logic [3:0] dCnt;
        logic dTc;
        logic [3:0] bCnt;
        logic bTc;
    } sspc_row_t;
    // Control field is load_n, parallel enable, trickle enable.
    localparam sspc_row_t ROWS [10] = '{
        '{3'b000, 4'h7, 4'h7, 1'b0, 4'h7, 1'b0}, '{3'b111, 4'h0, 4'h8, 1'b0, 4'h8, 1'b0},
        '{3'b111, 4'h0, 4'h9, 1'b1, 4'h9, 1'b0}, '{3'b101, 4'h0, 4'h9, 1'b1, 4'h9, 1'b0},
        '{3'b110, 4'h0, 4'h9, 1'b0, 4'h9, 1'b0}, '{3'b111, 4'h0, 4'h0, 1'b0, 4'ha, 1'b0},
        '{3'b000, 4'he, 4'he, 1'b0, 4'he, 1'b0}, '{3'b111, 4'h0, 4'hf, 1'b0, 4'hf, 1'b1},
        '{3'b111, 4'h0, 4'h0, 1'b0, 4'h0, 1'b0}, '{3'b011, 4'hf, 4'hf, 1'b0, 4'hf, 1'b1}};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    sspc_ctrl_t countCtrl;
    logic [3:0] presetInputs;
    logic asyncClearN;
    logic syncClearN;
    sspc_bus_req_t busReq = '0;
    logic [3:0] dCount;
    logic [3:0] bCount;
    logic dTc;
    logic bTc;
    logic [31:0] dRdata;
    logic [31:0] bRdata;
    sspc_row_t r;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;

    always #4 clock = ~clock;

    sspc_pin_driver u_sspc_pin_driver (.countCtrl(countCtrl), .presetInputs(presetInputs),
        .asyncClearN(asyncClearN), .syncClearN(syncClearN));
    sspc_counter #(.MODULUS(DECADE_MODULUS), .ASYNC_CLEAR(1'b1)) u_sspc_counter (.clock(clock),
        .rst_n(rst_n), .asyncClearN(asyncClearN), .syncClearN(syncClearN), .countCtrl(countCtrl),
        .presetInputs(presetInputs), .countOutputs(dCount), .terminalCountFlag(dTc),
        .busReq(busReq), .busRdata(dRdata));
    sspc_counter #(.MODULUS(BINARY_MODULUS), .ASYNC_CLEAR(1'b0)) u_sspc_counter_bin (.clock(clock),
        .rst_n(rst_n), .asyncClearN(asyncClearN), .syncClearN(syncClearN), .countCtrl(countCtrl),
        .presetInputs(presetInputs), .countOutputs(bCount), .terminalCountFlag(bTc),
        .busReq(busReq), .busRdata(bRdata));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] expD, input logic [31:0] expB);
        @(posedge clock);
        busReq <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        busReq.rd <= 1'b0;
        #1;
        check(dRdata, expD);
        check(bRdata, expB);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        busReq.wr <= 1'b0;
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // A hang counts as a mismatch; the whole run needs about 57 cycles.
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 400)
        begin
            n_fail++;
            test_done();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check({dTc, dCount, bTc, bCount, dRdata | bRdata}, 42'h0);
        $display("Reset test done");
        // Each row's outputs are checked at the edge that applies the next row.
        for (int i = 0; i <= 10; i++)
        begin
            @(posedge clock);
            if (i < 10)
                u_sspc_pin_driver.drive(ROWS[i].ctl[2], ROWS[i].ctl[1], ROWS[i].ctl[0],
                    ROWS[i].pre);
            #1;
            if (i > 0)
            begin
                r = ROWS[i - 1];
                check({dCount, dTc, bCount, bTc}, r[9:0]);
            end
        end
        $display("Table test done");
        for (int i = 0; i <= 17; i++)
        begin
            @(posedge clock);
            if (i == 0)
                u_sspc_pin_driver.drive(1'b0, 1'b0, 1'b0, 4'h0);
            else if (i < 17)
                u_sspc_pin_driver.drive(1'b1, 1'b1, 1'b1, 4'h0);
            else
                u_sspc_pin_driver.drive(1'b1, 1'b0, 1'b0, 4'h0);
            #1;
            if (i > 0)
                check({dCount, bCount}, {4'((i-1) % 10), 4'((i-1) % 16)});
        end
        $display("Sequence test done");
        rd(OFFS_CONFIG, 32'h0000_010a, 32'h0000_0010);
        rd(4'h2, 32'h0, 32'h0);
        rd(OFFS_STATUS, 32'h0000_0806, 32'h0000_0800);
        wr(OFFS_CONTROL, 32'h1);
        rd(OFFS_CONTROL, 32'h1, 32'h1);
        @(posedge clock);
        u_sspc_pin_driver.drive(1'b1, 1'b1, 1'b1, 4'h0);
        @(posedge clock);
        #1;
        check({dCount, bCount}, 8'h60);
        @(posedge clock);
        u_sspc_pin_driver.drive(1'b1, 1'b0, 1'b0, 4'h0);
        wr(OFFS_CONTROL, 32'h0);
        rd(OFFS_WRAPS, 32'h2, 32'h2);
        wr(OFFS_WRAPS, 32'h0);
        rd(OFFS_WRAPS, 32'h0, 32'h0);
        $display("Register test done");
        @(posedge clock);
        u_sspc_pin_driver.drive(1'b0, 1'b0, 1'b0, 4'h5);
        u_sspc_pin_driver.clears(1'b1, 1'b0);
        @(posedge clock);
        #1;
        check({dCount, bCount, bTc}, 9'h0a0);
        @(posedge clock);
        u_sspc_pin_driver.clears(1'b0, 1'b1);
        #1;
        check({dCount, dTc}, 5'h00);
        @(posedge clock);
        u_sspc_pin_driver.clears(1'b1, 1'b1);
        $display("Clear test done");
        test_done();
    end
endmodule // sspc_counter_bench
